/* common/icss_pkg.sv */
// Types for the interleaved camera strobe sequencer
`include "icss_regs.svh"
package icss_pkg;
  typedef struct packed {
    logic [`ICSS_CNT_W-1:0] expo_delay;
    logic [`ICSS_CNT_W-1:0] expo_time;
    logic [`ICSS_CNT_W-1:0] strobe_delay;
    logic [`ICSS_CNT_W-1:0] strobe_dur;
    logic [`ICSS_CNT_W-1:0] next_trig;
    logic [1:0] strobe_route;
  } icss_prog_t;
  typedef enum logic [1:0] {
    ICSS_IDLE = 2'b01,
    ICSS_RUN = 2'b10
  } icss_state_t;
endpackage : icss_pkg

/* common/icss_regs.svh */
// Timing and field constants for the interleaved camera strobe sequencer
`ifndef ICSS_REGS_SVH
`define ICSS_REGS_SVH
`define ICSS_CNT_W 24
`define ICSS_ROUTE_NONE 2'h0
`define ICSS_ROUTE_ONE 2'h1
`define ICSS_ROUTE_TWO 2'h2
`define ICSS_MODE_SINGLE_SHOT 2'h0
`define ICSS_MODE_HIGH_FRAME_RATE 2'h1
`define ICSS_CC_LINES 4
`endif

/* logic/icss_sequencer.sv */
// Interleaved camera exposure and strobe sequencer
//
// What this block does
// - With interleave on, two independent programs each hold exposure and strobe timing and routing.
// - Each cycle yields one Reset pulse; rising starts exposure, falling ends it.
// - Each cycle yields one Strobe pulse on the output its program selects.
// - Programs alternate on successive cycles; the first cycle always uses program one.
// - Each illumination device is driven only by its own strobe output.
// - Area-scan interleaving works only in single-shot and high-frame-rate modes.
// - Area-scan sequence: first cycle uses program one, second uses program two.
// - With short exposures, second exposure may start during first readout.
// - Second Reset timing lets its exposure end with the first readout.
// - Stretching second exposure to readout time lets strobes follow back to back.
// - Alternation restarts at every start of scan, so program one comes first.
// - Both Reset pulses are ORed and drivable on any of four control lines.
// - Each strobe routes to output one, two or neither; shared outputs are ORed.
// - A trigger before next-trigger-permitted raises a trigger-violation error.
`timescale 1ns/1ps
`include "icss_regs.svh"
module icss_sequencer
  import icss_pkg::*;
#(
  parameter int CNT_W = `ICSS_CNT_W
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic interleave_en_in,
  input wire logic area_scan_in,
  input wire logic [1:0] acq_mode_in,
  input wire logic cycle_trigger_in,
  input wire logic start_of_scan_in,
  input wire icss_prog_t first_cycle_program_in,
  input wire icss_prog_t second_cycle_program_in,
  input wire logic [`ICSS_CC_LINES-1:0] reset_line_sel_in,
  output logic [`ICSS_CC_LINES-1:0] camera_ctrl_out,
  output logic strobe_out_one,
  output logic strobe_out_two,
  output logic trigger_violation_out,
  output logic mode_refused_out,
  output logic active_program_out,
  output logic busy_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter check
  if (CNT_W != `ICSS_CNT_W) begin : g_bad_width
    $error("icss_sequencer: CNT_W must match the program field width");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronise pin inputs and find their rising edges
  wire trig_rise;
  wire sos_rise;

  icss_pin_edge #(
    .STAGES(2)
  ) u_trig_edge (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .pin_in(cycle_trigger_in),
    .rise_out(trig_rise)
  );

  icss_pin_edge #(
    .STAGES(2)
  ) u_sos_edge (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .pin_in(start_of_scan_in),
    .rise_out(sos_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mode gating and program selection
  wire mode_ok = ~area_scan_in | (acq_mode_in == `ICSS_MODE_SINGLE_SHOT) |
                 (acq_mode_in == `ICSS_MODE_HIGH_FRAME_RATE);
  wire interleave_on = interleave_en_in & mode_ok;

  icss_state_t state;
  icss_state_t next_state;
  logic use_second;
  logic next_program;
  logic [CNT_W-1:0] elapsed;
  icss_prog_t run_prog;

  // Program for this trigger; a start of scan in the same cycle forces program one
  wire start_prog = sos_rise ? 1'b0 : (interleave_on & next_program);
  // Program after this trigger: the other one in interleave, program one otherwise
  wire next_after_start = interleave_on & ~start_prog;
  wire running = (state == ICSS_RUN);
  wire trig_permitted = (elapsed >= run_prog.next_trig);
  wire early_trig = trig_rise & running & ~trig_permitted;
  wire accept_trig = trig_rise & ~early_trig;
  // Selected program is captured whole at trigger, so edits mid-cycle are safe
  icss_prog_t sel_prog;
  assign sel_prog = start_prog ? second_cycle_program_in : first_cycle_program_in;

  ////////////////////////////////////////////////////////////////////////////
  // Pulse windows on the cycle counter
  wire reset_pulse;
  wire reset_done;
  wire strobe_pulse;
  wire strobe_done;

  icss_pulse_window #(
    .CNT_W(CNT_W)
  ) u_reset_window (
    .running_in(running),
    .elapsed_in(elapsed),
    .start_in(run_prog.expo_delay),
    .length_in(run_prog.expo_time),
    .active_out(reset_pulse),
    .finished_out(reset_done)
  );

  icss_pulse_window #(
    .CNT_W(CNT_W)
  ) u_strobe_window (
    .running_in(running),
    .elapsed_in(elapsed),
    .start_in(run_prog.strobe_delay),
    .length_in(run_prog.strobe_dur),
    .active_out(strobe_pulse),
    .finished_out(strobe_done)
  );

  wire run_done = reset_done & strobe_done & trig_permitted;

  always_comb begin
    next_state = state;
    unique case (state)
      ICSS_IDLE: begin
        if (accept_trig) begin
          next_state = ICSS_RUN;
        end
      end
      ICSS_RUN: begin
        if (run_done & ~trig_rise) begin
          next_state = ICSS_IDLE;
        end
      end
      default: begin
        next_state = ICSS_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle state
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      state <= ICSS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle counter, restarted by every accepted trigger and saturating at the top
  wire count_held = ~running | (&elapsed);
  wire [CNT_W-1:0] elapsed_inc = elapsed + 1'b1;
  wire [CNT_W-1:0] next_elapsed;
  assign next_elapsed = accept_trig ? '0 : (count_held ? elapsed : elapsed_inc);

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      elapsed <= '0;
    end else begin
      elapsed <= next_elapsed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Running program, captured whole at every accepted trigger
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      run_prog <= '0;
    end else if (accept_trig) begin
      run_prog <= sel_prog;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program alternation
  // A start of scan clears the pending choice even when no trigger is taken
  wire next_pending_prog = accept_trig ? next_after_start : (sos_rise ? 1'b0 : next_program);

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      next_program <= 1'b0;
    end else begin
      next_program <= next_pending_prog;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      use_second <= 1'b0;
    end else if (accept_trig) begin
      use_second <= start_prog;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output routing
  wire route_one = strobe_pulse & (run_prog.strobe_route == `ICSS_ROUTE_ONE);
  wire route_two = strobe_pulse & (run_prog.strobe_route == `ICSS_ROUTE_TWO);
  wire [`ICSS_CC_LINES-1:0] next_camera_ctrl = reset_line_sel_in & {`ICSS_CC_LINES{reset_pulse}};
  wire next_mode_refused = interleave_en_in & ~mode_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      camera_ctrl_out <= '0;
    end else begin
      camera_ctrl_out <= next_camera_ctrl;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      strobe_out_one <= 1'b0;
      strobe_out_two <= 1'b0;
    end else begin
      strobe_out_one <= route_one;
      strobe_out_two <= route_two;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      trigger_violation_out <= 1'b0;
      mode_refused_out <= 1'b0;
    end else begin
      trigger_violation_out <= early_trig;
      mode_refused_out <= next_mode_refused;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      active_program_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      active_program_out <= use_second;
      busy_out <= running;
    end
  end

endmodule : icss_sequencer

////////////////////////////////////////////////////////////////////////////////
// Pin synchroniser with rising-edge detect
module icss_pin_edge #(
  parameter int STAGES = 2
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic pin_in,
  output logic rise_out
);

  if (STAGES < 2) begin : g_bad_stages
    $error("icss_pin_edge: STAGES must be at least two");
  end

  // Top bit is the edge history, fed only by the last synchroniser stage
  logic [STAGES:0] sync_q;

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      sync_q <= '0;
    end else begin
      sync_q <= {sync_q[STAGES-1:0], pin_in};
    end
  end

  assign rise_out = sync_q[STAGES-1] & ~sync_q[STAGES];

endmodule : icss_pin_edge

////////////////////////////////////////////////////////////////////////////////
// Pulse window on a cycle counter
module icss_pulse_window #(
  parameter int CNT_W = 24
) (
  input wire logic running_in,
  input wire logic [CNT_W-1:0] elapsed_in,
  input wire logic [CNT_W-1:0] start_in,
  input wire logic [CNT_W-1:0] length_in,
  output logic active_out,
  output logic finished_out
);

  if (CNT_W < 1) begin : g_bad_width
    $error("icss_pulse_window: CNT_W must be at least one");
  end

  // One extra bit keeps start plus length from wrapping
  wire [CNT_W:0] edge_on = {1'b0, start_in};
  wire [CNT_W:0] edge_off = edge_on + {1'b0, length_in};
  wire [CNT_W:0] count_w = {1'b0, elapsed_in};
  assign active_out = running_in & (count_w >= edge_on) & (count_w < edge_off);
  assign finished_out = (count_w >= edge_off);
endmodule : icss_pulse_window

/* testbench/icss_cam_model.sv */
// Camera and lamp model measuring each pulse
`timescale 1ns/1ps
module icss_cam_model (
  input wire logic clk_in,
  input wire logic expose_in,
  input wire logic lamp_one_in,
  input wire logic lamp_two_in,
  output logic frame_out,
  output logic [23:0] meas_out
);
  logic [7:0] e = 8'h0, a = 8'h0, b = 8'h0;
  initial frame_out = 1'b0;
  always @(posedge clk_in) begin
    frame_out <= 1'b0;
    e <= e + expose_in;
    a <= a + lamp_one_in;
    b <= b + lamp_two_in;
    if (!expose_in && e != 8'h0) begin
      meas_out <= {e, a, b};
      frame_out <= 1'b1;
      {e, a, b} <= 24'h00_0000;
    end
  end
endmodule : icss_cam_model

/* testbench/icss_sequencer_chk.sv */
// Port assertions for the sequencer
`timescale 1ns/1ps
module icss_sequencer_chk (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic interleave_en_in,
  input wire logic area_scan_in,
  input wire logic [1:0] acq_mode_in,
  input wire logic [3:0] reset_line_sel_in,
  input wire logic [3:0] camera_ctrl_out,
  input wire logic strobe_out_one,
  input wire logic strobe_out_two,
  input wire logic trigger_violation_out,
  input wire logic mode_refused_out,
  input wire logic active_program_out,
  input wire logic busy_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  viol_pulse_a: assert property (trigger_violation_out |=> !trigger_violation_out) else $error("long");
  viol_busy_a: assert property (trigger_violation_out |-> $past(busy_out)) else $error("idle viol");
  reset_or_a: assert property ($stable(reset_line_sel_in) |-> camera_ctrl_out == 4'h0
    || camera_ctrl_out == reset_line_sel_in) else $error("ctrl lines");
  reset_busy_a: assert property (|camera_ctrl_out |-> busy_out) else $error("stray reset");
  strobe_busy_a: assert property (strobe_out_one || strobe_out_two |-> busy_out) else $error("stray");
  mode_gate_a: assert property (!$past(sys_rst_in) |-> mode_refused_out ==
    $past(interleave_en_in && area_scan_in && acq_mode_in[1])) else $error("mode");
  single_prog_a: assert property ($rose(busy_out) && !interleave_en_in |-> !active_program_out) else $error("p");
  refused_prog_a: assert property ($rose(busy_out) && mode_refused_out |-> !active_program_out) else $error("p");
  strobe_excl_a: assert property (!(strobe_out_one && strobe_out_two)) else $error("both strobes");
endmodule : icss_sequencer_chk
bind icss_sequencer icss_sequencer_chk chk (.*);

/* testbench/test_icss_sequencer.sv */
// Self-checking bench for the sequencer
`timescale 1ns/1ps
module test_icss_sequencer;
  import icss_pkg::*;
  logic sys_clk_in = 1'b0, sys_rst_in = 1'b1, ien = 1'b1, area = 1'b1, trig = 1'b0, sos = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [3:0] sel = 4'h5, ctrl;
  icss_prog_t p1 = '0, p2 = '0;
  logic s1, s2, viol, refd, prog, busy, frame;
  logic [23:0] meas;
  int mismatches = 0, checks_done = 0, nviol = 0;
  logic [24:0] q[$];
  icss_sequencer uut (.sys_clk_in, .sys_rst_in, .interleave_en_in(ien), .area_scan_in(area), .acq_mode_in(mode),
    .cycle_trigger_in(trig), .start_of_scan_in(sos), .first_cycle_program_in(p1), .second_cycle_program_in(p2),
    .reset_line_sel_in(sel), .camera_ctrl_out(ctrl), .strobe_out_one(s1), .strobe_out_two(s2),
    .trigger_violation_out(viol), .mode_refused_out(refd), .active_program_out(prog), .busy_out(busy));
  icss_cam_model cam (.clk_in(sys_clk_in), .expose_in(ctrl[0]), .lamp_one_in(s1), .lamp_two_in(s2),
    .frame_out(frame), .meas_out(meas));
  initial forever #5 sys_clk_in = ~sys_clk_in;
  task automatic check(input string what, input logic [24:0] seen, input logic [24:0] want);
    checks_done++;
    if (seen !== want) begin
      mismatches++;
      $display("MISMATCH %s exp %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic test_done();
    if (mismatches == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  function automatic icss_prog_t mk(input logic [1:0] r);
    logic [23:0] e;
    e = 24'(4 + $urandom % 12);
    return '{24'h2, e, 24'h3, 24'(1 + $urandom % (e - 1)), 24'h28, r};
  endfunction : mk
  task automatic pin(input bit s, input int n);
    if (s) sos <= 1'b1;
    else trig <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    {trig, sos} <= 2'h0;
    repeat (n) @(posedge sys_clk_in);
  endtask : pin
  task automatic run(input bit pn, input int n);
    icss_prog_t p;
    p = pn ? p2 : p1;
    q.push_back({p.expo_time[7:0], (p.strobe_route == 2'h1) ? p.strobe_dur[7:0] : 8'h0,
      (p.strobe_route == 2'h2) ? p.strobe_dur[7:0] : 8'h0, pn});
    pin(0, n);
  endtask : run
  always @(posedge sys_clk_in) begin
    if (viol === 1'b1) nviol++;
    if (frame === 1'b1) check("cycle", {meas, prog}, q.pop_front());
  end
  initial begin
    void'($urandom(81951));
    repeat (5) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      p1 <= mk(i[1:0]);
      p2 <= mk(2'(i + 1));
      sel <= i[2] ? 4'hF : 4'h5;
      mode <= 2'(i[2]);
      @(posedge sys_clk_in);
      run(i[0], 50);
    end
    run(0, 50);
    pin(1, 4);
    run(0, 4);
    pin(0, 50);
    run(1, 50);
    ien <= 1'b0;
    run(0, 50);
    run(0, 50);
    ien <= 1'b1;
    mode <= 2'h3;
    run(0, 50);
    run(0, 50);
    area <= 1'b0;
    run(0, 50);
    sos <= 1'b1;
    run(0, 50);
    run(1, 50);
    check("violations", 25'(nviol), 25'h1);
    check("pending", 25'(q.size()), 25'h0);
    test_done();
  end
endmodule : test_icss_sequencer
